/* logic/txm_top.v */
// AXI4-Lite control register and registered modulated transmit output.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "txm_map.vh"
module txm_top (
	// Clock and reset
	input  wire        aclk,
	input  wire        aresetn,
	// AXI4-Lite write address
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [7:0]  s_axi_awaddr,
	// AXI4-Lite write data
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	// AXI4-Lite write response
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	output reg  [1:0]  s_axi_bresp,
	// AXI4-Lite read address
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	input  wire [7:0]  s_axi_araddr,
	// AXI4-Lite read data
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	// Serial line and carriers
	input  wire        serial_transmit_line,
	input  wire [3:0]  carrier_pwm_unit,
	output reg         modulated_tx
);
	reg  [31:0] tx_modulation_control;
	reg         aw_held;
	reg  [7:0]  aw_addr;
	reg         w_held;
	reg  [31:0] w_data;
	reg  [3:0]  w_strb;
	wire        mixed;
	wire        aw_take;
	wire        w_take;
	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take  = s_axi_wvalid && s_axi_wready;
	// ==================================================================
	// Write channel: address and data taken in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `TXM_RESP_OKAY;
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_addr <= 8'h00;
			w_data <= 32'h00000000;
			w_strb <= 4'h0;
			tx_modulation_control <= `TXM_CTRL_RESET;
		end else begin
			s_axi_awready <= !aw_held && !aw_take && !s_axi_bvalid;
			s_axi_wready <= !w_held && !w_take && !s_axi_bvalid;
			if (aw_take) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (w_take) begin
				w_held <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (aw_held && w_held && !s_axi_bvalid) begin
				s_axi_bvalid <= 1'b1;
				aw_held <= 1'b0;
				w_held <= 1'b0;
				if ({aw_addr[7:2], 2'b00} == `TXM_CTRL_OFFSET) begin
					s_axi_bresp <= `TXM_RESP_OKAY;
					// Only byte lane 0 holds fields; reserved bits stay zero.
					if (w_strb[0]) begin
						tx_modulation_control <= w_data
							& `TXM_CTRL_MASK;
					end
				end else begin
					s_axi_bresp <= `TXM_RESP_SLVERR;
				end
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// ==================================================================
	// Read channel
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `TXM_RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				if ({s_axi_araddr[7:2], 2'b00} == `TXM_CTRL_OFFSET) begin
					s_axi_rdata <= tx_modulation_control;
					s_axi_rresp <= `TXM_RESP_OKAY;
				end else begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `TXM_RESP_SLVERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
	// ==================================================================
	// Modulation path
	txm_mix u_mix (
		.modulation_enable      (tx_modulation_control[`TXM_EN_BIT]),
		.pulse_level_select     (tx_modulation_control[`TXM_POL_BIT]),
		.carrier_channel_select (tx_modulation_control[`TXM_SEL_HI:`TXM_SEL_LO]),
		.carrier_pwm_unit       (carrier_pwm_unit),
		.serial_transmit_line   (serial_transmit_line),
		.mixed                  (mixed)
	);
	// Registered so the pin is glitch free; costs one cycle of latency.
	always @(posedge aclk) begin
		if (!aresetn) begin
			modulated_tx <= `TXM_IDLE_LEVEL;
		end else begin
			modulated_tx <= mixed;
		end
	end
endmodule // txm_top

/* logic/txm_map.vh */
// Register map, field positions and reset values of the transmit modulator.
// Behaviour
// - With the enable bit (bit 0) set, the selected carrier is combined with the serial transmit line; cleared, modulation is off.
// - Polarity bit 1 at 1 puts pulses while the transmit line is high, at 0 while it is low.
// - Select field bits 6 to 4 picks carrier channel 0 to 3 for codes 000 to 011; other codes are reserved.
// - The select field affects the output only while the enable bit is 1.
`ifndef TXM_MAP_VH
`define TXM_MAP_VH
// ==========================================================================
// Register offsets and fields
`define TXM_CTRL_OFFSET     8'hc0
`define TXM_ADDR_W          8
`define TXM_CTRL_RESET      32'h00000000
`define TXM_EN_BIT          0
`define TXM_POL_BIT         1
`define TXM_SEL_HI          6
`define TXM_SEL_LO          4
`define TXM_SEL_W           3
`define TXM_CTRL_MASK       32'h00000073
`define TXM_NUM_CH          4
`define TXM_IDLE_LEVEL      1'b1
`define TXM_RESP_OKAY       2'b00
`define TXM_RESP_SLVERR     2'b10
`endif

/* logic/txm_mix.v */
// Combinational carrier selection and mixing with the transmit line.
`timescale 1ns/1ps
`include "txm_map.vh"
module txm_mix (
	// Control fields
	input  wire                  modulation_enable,
	input  wire                  pulse_level_select,
	input  wire [`TXM_SEL_W-1:0] carrier_channel_select,
	// Signals to mix
	input  wire [`TXM_NUM_CH-1:0] carrier_pwm_unit,
	input  wire                  serial_transmit_line,
	// Mixed result
	output reg                   mixed
);
	reg carrier;
	reg pulse_phase;
	// ==================================================================
	// Selection and mixing
	always @* begin
		carrier = 1'b0;
		// Reserved codes give no carrier, so pulse phases drive the line low.
		if (carrier_channel_select < `TXM_NUM_CH) begin
			carrier = carrier_pwm_unit[carrier_channel_select[1:0]];
		end
		pulse_phase = (serial_transmit_line == pulse_level_select);
		if (!modulation_enable) begin
			mixed = serial_transmit_line;
		end else if (pulse_phase) begin
			mixed = carrier;
		end else begin
			mixed = `TXM_IDLE_LEVEL;
		end
	end
endmodule // txm_mix

/* tb/txm_monitor.sv */
// Checker of the modulated transmit output.
`timescale 1ns/1ps
module txm_monitor (
	// ==== Watched ports
	input wire logic        aclk, aresetn, serial_transmit_line,
	input wire logic        modulated_tx, s_axi_wvalid, s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0]  s_axi_wstrb, carrier_pwm_unit,
	input wire logic [1:0]  s_axi_bresp
);
	// The word is rebuilt from the bus; it lands as bvalid rises.
	logic [6:0] pend, ctl;
	logic       bq, wen;
	wire  [6:0] cur = (s_axi_bvalid && !bq && s_axi_bresp == 2'h0 && wen)
		? pend : ctl;
	wire        ph = serial_transmit_line == cur[1];
	wire        carr = carrier_pwm_unit[cur[5:4]];
	always @(posedge aclk) begin
		bq <= s_axi_bvalid;
		ctl <= aresetn ? cur : 7'h00;
		if (s_axi_wvalid && s_axi_wready) begin
			pend <= s_axi_wdata[6:0] & 7'h73;
			wen <= s_axi_wstrb[0];
		end
	end
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	sequence pulse_s; cur[0] && ph; endsequence
	AST_OFF: assert property (!cur[0] |=>
		modulated_tx == $past(serial_transmit_line)) else $error("off path");
	AST_SEL: assert property (!cur[0] && cur[6:4] != 3'h0 ##1 !cur[0] |->
		modulated_tx == $past(serial_transmit_line)) else $error("select leak");
	AST_PULSE: assert property (pulse_s ##0 !cur[6] |=>
		modulated_tx == $past(carr)) else $error("wrong carrier");
	AST_RSV: assert property (pulse_s ##0 cur[6] |=> !modulated_tx)
		else $error("reserved code");
	AST_IDLE: assert property (cur[0] && !ph |=> modulated_tx)
		else $error("idle level");
endmodule // txm_monitor
bind txm_top txm_monitor mon (.*);

/* tb/txm_far_model.sv */
// Stand-in for the serial transmitter and the four carrier channels.
`timescale 1ns/1ps
module txm_far_model (
	// ==== Clock and driven lines
	input  wire logic  aclk,
	output logic       serial_transmit_line = 1'b1,
	output logic [3:0] carrier_pwm_unit = 4'h0
);
	// Each channel runs at its own rate so a wrong pick shows.
	logic [7:0] t = 8'h00;
	always @(posedge aclk) begin
		t <= t + 8'h01;
		serial_transmit_line <= t[4] ^ t[6];
		carrier_pwm_unit <= t[3:0];
	end
endmodule // txm_far_model

/* tb/txm_top_test.sv */
// Register bus test of the transmit modulator.
`timescale 1ns/1ps
module txm_top_test;
	// ==== Signals and counters
	logic aclk = 1'b0, aresetn = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	wire s_axi_rvalid, modulated_tx, serial_transmit_line;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	wire [3:0] carrier_pwm_unit;
	int fails = 0, tests_run = 0, cyc = 0;
	txm_top dut (.*);
	txm_far_model far (.aclk(aclk), .serial_transmit_line(serial_transmit_line),
		.carrier_pwm_unit(carrier_pwm_unit));
	always #2.5 aclk = ~aclk;
	task give_verdict;
		if (fails == 0 && tests_run > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		tests_run++;
		if (g !== e) begin
			fails++;
			$display("unexpected at %0t: got %h want %h", $time, g, e);
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while ((s_axi_awvalid && !s_axi_awready) ||
			(s_axi_wvalid && !s_axi_wready));
		while (!s_axi_bvalid) @(posedge aclk);
		chk({30'h0, s_axi_bresp}, {30'h0, r});
		s_axi_bready <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge aclk); while (!s_axi_arready);
		s_axi_arvalid <= 1'b0;
		do @(posedge aclk); while (!s_axi_rvalid);
		chk(s_axi_rdata, e);
		chk({30'h0, s_axi_rresp}, {30'h0, r});
		s_axi_rready <= 1'b0;
	endtask
	// A hung handshake would otherwise stall the run for ever.
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 6000) begin
			fails++;
			give_verdict;
		end
	end
	initial begin
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd(8'hc0, 32'h0, 2'h0);
		for (int k = 0; k < 32; k++) begin
			wr(8'hc0, {25'h1ffffff, k[4:2], 2'h3, k[1:0]}, 4'hf, 2'h0);
			rd(8'hc0, {25'h0, k[4:2], 2'h0, k[1:0]}, 2'h0);
			repeat (40) @(posedge aclk);
		end
		wr(8'hc0, 32'h0, 4'he, 2'h0);
		wr(8'hc4, 32'h1, 4'hf, 2'h2);
		rd(8'hc4, 32'h0, 2'h2);
		rd(8'hc0, 32'h73, 2'h0);
		give_verdict;
	end
endmodule // txm_top_test
